// File: hdl/bfiu_exec.sv
// Contract
// - I/O bit set, two cycles, flags kept
// - I/O bit clear, two cycles, flags kept
// - Shift up, zero in, ZCNV, one cycle
// - Shift down, zero in, ZCNV, one cycle
// - Rotate up through carry, ZCNV, one cycle
// - Rotate down through carry, ZCNV, one cycle
// - Arithmetic shift down keeps bit seven, ZCNV
// - Selected bit into T, one cycle
// - T into selected bit, flags kept
// - Set or clear H only, one cycle
// - Set or clear S only, one cycle
// - Set V only, one cycle
// - Sleep request, one cycle, flags kept
// - Watchdog restart pulse, one cycle, flags kept
// - Break to debug, flags kept
module bfiu_exec
    import bfiu_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Instruction request
    input wire logic req_valid_i,
    input wire bfiu_req_s req_i,
    output logic ready_o,
    output logic done_o,
    // Register file write-back
    output bfiu_wb_s wb_o,
    // I/O space
    output bfiu_io_s io_o,
    input wire logic [7:0] io_rdata_i,
    // System control pulses
    output logic sleep_req_o,
    output logic wdog_req_o,
    output logic break_req_o,
    // Live flags
    output logic [7:0] flags_o,
    // Plain register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // One _nxt per register: the combinational blocks are the only
    // writers of the _nxt values, the clocked blocks the only writers
    // of the _r values, so every output is a plain flop.
    bfiu_state_e state_r, state_nxt;   // Sequencer
    logic [7:0] flags_r, flags_nxt;    // status_flags_register
    logic [7:0] result_r, result_nxt;  // Last result byte
    logic [7:0] io_byte_r, io_byte_nxt; // Last I/O byte written
    bfiu_req_s held_r, held_nxt;       // Request held across the I/O read
    bfiu_wb_s wb_r, wb_nxt;            // Write-back
    bfiu_io_s io_r, io_nxt;            // I/O access
    logic ready_r, ready_nxt;          // Accepting requests
    logic done_r, done_nxt;            // Completion pulse
    logic sleep_r, sleep_nxt;          // Sleep request pulse
    logic wdog_r, wdog_nxt; // Watchdog restart pulse
    logic brk_r, brk_nxt;              // Debug break pulse
    logic [7:0] rdata_r, rdata_nxt;    // Register read data

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Shifts compute result and flags here; the I/O bit ops are a
    // read-modify-write, so they hold the sequencer for a second cycle.
    always_comb begin
        logic [7:0] d;
        logic [7:0] res;
        logic [7:0] f;
        logic take;
        logic shift_flags;
        logic c_new;
        d = req_i.operand;
        res = DATA_RST;
        f = flags_r;
        take = req_valid_i && ready_r;
        shift_flags = 1'b0;
        c_new = 1'b0;
        state_nxt = state_r;
        flags_nxt = flags_r;
        result_nxt = result_r;
        io_byte_nxt = io_byte_r;
        held_nxt = held_r;
        wb_nxt = '0;
        io_nxt = '0;
        io_nxt.addr = io_r.addr;
        done_nxt = 1'b0;
        sleep_nxt = 1'b0;
        wdog_nxt = 1'b0;
        brk_nxt = 1'b0;

        // Software write to the flags; an executing op overrides it below
        // Bits that the op leaves alone keep the written value
        if (reg_we_i && (reg_addr_i == REG_FLAGS)) begin
            flags_nxt = reg_wdata_i;
            f = reg_wdata_i;
        end

        // One-cycle ops finish from ST_IDLE; the I/O bit ops spend their
        // second cycle in ST_IO_READ, where ready is low and requests wait
        unique case (state_r)
            ST_IDLE: begin
                // Requests are only taken here
                if (take) begin
                    unique case (req_i.op)
                        io_bit_set_op, io_bit_clear_op: begin
                            // First cycle: fetch the I/O byte, flags untouched
                            held_nxt = req_i;
                            io_nxt.re = 1'b1;
                            io_nxt.addr = req_i.io_addr;
                            state_nxt = ST_IO_READ;
                        end
                        // Shift family; the bit shifted out becomes the new carry
                        logical_shift_up: begin
                            res = {d[6:0], 1'b0};
                            c_new = d[7];
                            shift_flags = 1'b1;
                        end
                        logical_shift_down: begin
                            res = {1'b0, d[7:1]};
                            c_new = d[0];
                            shift_flags = 1'b1;
                        end
                        rotate_up_through_carry: begin
                            res = {d[6:0], flags_r[FLAG_C]};
                            c_new = d[7];
                            shift_flags = 1'b1;
                        end
                        rotate_down_through_carry: begin
                            res = {flags_r[FLAG_C], d[7:1]};
                            c_new = d[0];
                            shift_flags = 1'b1;
                        end
                        arith_shift_down: begin
                            res = {d[7], d[7:1]};
                            c_new = d[0];
                            shift_flags = 1'b1;
                        end
                        // Swap and transfer-bit ops leave Z, C, N and V alone
                        nibble_swap_op: begin
                            res = {d[3:0], d[7:4]};
                        end
                        bit_to_transfer_flag: begin
                            f[FLAG_T] = d[req_i.bit_sel];
                        end
                        transfer_flag_to_bit: begin
                            res = d;
                            res[req_i.bit_sel] = flags_r[FLAG_T];
                        end
                        // Single-flag ops touch only the flag they name
                        flag_set_op: f[req_i.bit_sel] = 1'b1;
                        flag_clear_op: f[req_i.bit_sel] = 1'b0;
                        half_carry_set_op: f[FLAG_H] = 1'b1;
                        half_carry_clear_op: f[FLAG_H] = 1'b0;
                        sign_flag_set_op: f[FLAG_S] = 1'b1;
                        sign_flag_clear_op: f[FLAG_S] = 1'b0;
                        overflow_set_op: f[FLAG_V] = 1'b1;
                        // Control ops only pulse the logic that owns them; flags kept
                        sleep_op: sleep_nxt = 1'b1;
                        watchdog_restart_op: wdog_nxt = 1'b1;
                        break_op: brk_nxt = 1'b1;
                        default: ; // No operation
                    endcase

                    // Shift family: Z, C, N, V; V is N xor C after the shift
                    // S is left alone, the shift family does not update it
                    if (shift_flags) begin
                        f[FLAG_Z] = (res == DATA_RST);
                        f[FLAG_C] = c_new;
                        f[FLAG_N] = res[7];
                        f[FLAG_V] = res[7] ^ c_new;
                    end

                    // Ops that write a register back
                    // The byte is also kept for the register port
                    unique case (req_i.op)
                        logical_shift_up, logical_shift_down, rotate_up_through_carry,
                        rotate_down_through_carry, arith_shift_down, nibble_swap_op,
                        transfer_flag_to_bit: begin
                            wb_nxt.we = 1'b1;
                            wb_nxt.idx = req_i.reg_idx;
                            wb_nxt.data = res;
                            result_nxt = res;
                        end
                        default: ;
                    endcase

                    // The op's flag image replaces any software write of this cycle
                    flags_nxt = f;
                    // One-cycle ops complete here; two-cycle ops complete in ST_IO_READ, with their I/O write
                    done_nxt = (state_nxt == ST_IDLE);
                end
            end
            ST_IO_READ: begin
                // Second cycle: modify the fetched byte and write it back
                // The read data are taken at this edge, so the I/O space must
                // answer with no wait state; a slow device would need a stall
                io_nxt.we = 1'b1;
                io_nxt.addr = held_r.io_addr;
                io_nxt.wdata = io_rdata_i;
                // Only the selected bit changes; the rest go back as read
                if (held_r.op == io_bit_set_op) begin
                    io_nxt.wdata[held_r.bit_sel] = 1'b1;
                end else begin
                    io_nxt.wdata[held_r.bit_sel] = 1'b0;
                end
                io_byte_nxt = io_nxt.wdata;
                done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE; // Recover from an illegal code
        endcase

        // Outside reset, ready is low in the cycle spent in ST_IO_READ and in the first cycle after reset
        ready_nxt = (state_nxt == ST_IDLE);
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    // Synchronous reset; all outputs are flops so they are defined
    // from the first edge with reset high.
    // Pulses are cleared here too; outside reset their _nxt values default to zero.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            flags_r <= FLAGS_RST;
            result_r <= DATA_RST;
            io_byte_r <= DATA_RST;
            held_r <= '0;
            wb_r <= '0;
            io_r <= '0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            sleep_r <= 1'b0;
            wdog_r <= 1'b0;
            brk_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
            result_r <= result_nxt;
            io_byte_r <= io_byte_nxt;
            held_r <= held_nxt;
            wb_r <= wb_nxt;
            io_r <= io_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            sleep_r <= sleep_nxt;
            wdog_r <= wdog_nxt;
            brk_r <= brk_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Kept apart from the sequencer: a read returns what the register
    // held before this edge, whatever op is in flight. A flag write in
    // the same cycle shows up only on the next read.
    always_comb begin
        // Idle cycles and unmapped addresses read as zero
        rdata_nxt = DATA_RST;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                REG_FLAGS: rdata_nxt = flags_r; // Before any same-cycle write
                REG_RESULT: rdata_nxt = result_r; // Last write-back byte
                REG_IO_BYTE: rdata_nxt = io_byte_r; // Last modified I/O byte
                default: rdata_nxt = DATA_RST; // Unmapped
            endcase
        end
    end

    // Read data stand for one cycle only, then fall back to zero
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_r <= DATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output is a flop, so nothing combinational reaches the
    // pins; the price is one cycle of latency on every answer.
    assign ready_o = ready_r;
    assign done_o = done_r;
    assign wb_o = wb_r;
    assign io_o = io_r;
    assign sleep_req_o = sleep_r;
    assign wdog_req_o = wdog_r;
    assign break_req_o = brk_r;
    assign flags_o = flags_r;
    assign reg_rdata_o = rdata_r;

endmodule : bfiu_exec

// File: common/bfiu_pkg.sv
package bfiu_pkg;

    // ----------------------------------------------------------------
    // Status flag bit positions
    // ----------------------------------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0; // Carry
    localparam logic [2:0] FLAG_Z = 3'h1; // Zero
    localparam logic [2:0] FLAG_N = 3'h2; // Negative
    localparam logic [2:0] FLAG_V = 3'h3; // Two's complement overflow
    localparam logic [2:0] FLAG_S = 3'h4; // Sign
    localparam logic [2:0] FLAG_H = 3'h5; // Half carry
    localparam logic [2:0] FLAG_T = 3'h6; // Transfer bit
    localparam logic [2:0] FLAG_I = 3'h7; // Global interrupt enable

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ----------------------------------------------------------------
    // Register port map (word index on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_FLAGS = 4'h0;  // status_flags_register, read/write
    localparam logic [3:0] REG_RESULT = 4'h1; // Last result byte, read only
    localparam logic [3:0] REG_IO_BYTE = 4'h2; // Last I/O byte written back, read only

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        op_nop,
        io_bit_set_op,
        io_bit_clear_op,
        logical_shift_up,
        logical_shift_down,
        rotate_up_through_carry,
        rotate_down_through_carry,
        arith_shift_down,
        nibble_swap_op,
        bit_to_transfer_flag,
        transfer_flag_to_bit,
        flag_set_op,
        flag_clear_op,
        half_carry_set_op,
        half_carry_clear_op,
        sign_flag_set_op,
        sign_flag_clear_op,
        overflow_set_op,
        sleep_op,
        watchdog_restart_op,
        break_op
    } bfiu_op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_IO_READ
    } bfiu_state_e;

    // Instruction request from the decoder
    typedef struct packed {
        bfiu_op_e op;       // Operation
        logic [7:0] operand; // Register operand
        logic [2:0] bit_sel; // Bit or flag select
        logic [4:0] reg_idx; // Destination register index
        logic [4:0] io_addr; // I/O address for bit set/clear
    } bfiu_req_s;

    // Register file write-back
    typedef struct packed {
        logic we;            // Write enable, one cycle
        logic [4:0] idx;     // Register index
        logic [7:0] data;    // Write data
    } bfiu_wb_s;

    // I/O space access
    typedef struct packed {
        logic re;            // Read strobe, one cycle
        logic we;            // Write strobe, one cycle
        logic [4:0] addr;    // I/O address
        logic [7:0] wdata;   // Write data
    } bfiu_io_s;

endpackage : bfiu_pkg

// File: tb/bfiu_exec_asserts.sv
// ------------
// Ports checker
// ------------
module bfiu_exec_asserts
    import bfiu_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire bfiu_req_s req_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire bfiu_wb_s wb_o,
    input wire bfiu_io_s io_o,
    input wire logic [7:0] io_rdata_i,
    input wire logic wdog_req_o,
    input wire logic [7:0] flags_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Request taken at this edge
    logic tk;
    assign tk = req_valid_i && ready_o;
    property p_io_set;
        tk && req_i.op == io_bit_set_op |=> io_o.re && !ready_o ##1 io_o.we && done_o
            && io_o.wdata == ($past(io_rdata_i) | (8'h01 << $past(req_i.bit_sel, 2)));
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set wrong");
    property p_io_clr;
        tk && req_i.op == io_bit_clear_op |=> io_o.re ##1 io_o.we && done_o
            && io_o.wdata == ($past(io_rdata_i) & ~(8'h01 << $past(req_i.bit_sel, 2)));
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
    // Two cycles with flags untouched; assumes no software flag write meanwhile
    property p_io_flags;
        tk && req_i.op inside {io_bit_set_op, io_bit_clear_op} |=> $stable(flags_o) [*2];
    endproperty
    a_io_flags: assert property (p_io_flags) else $error("io op moved flags");
    property p_shl;
        tk && req_i.op == logical_shift_up |=> wb_o.we && done_o
            && wb_o.data == {$past(req_i.operand[6:0]), 1'b0}
            && flags_o[FLAG_C] == $past(req_i.operand[7]);
    endproperty
    a_shl: assert property (p_shl) else $error("shift up wrong");
    property p_rot_up;
        tk && req_i.op == rotate_up_through_carry |=> wb_o.we
            && wb_o.data == {$past(req_i.operand[6:0]), $past(flags_o[FLAG_C])};
    endproperty
    a_rot_up: assert property (p_rot_up) else $error("rotate up wrong");
    property p_rot_dn;
        tk && req_i.op == rotate_down_through_carry |=> wb_o.we
            && wb_o.data == {$past(flags_o[FLAG_C]), $past(req_i.operand[7:1])}
            && flags_o[FLAG_C] == $past(req_i.operand[0]);
    endproperty
    a_rot_dn: assert property (p_rot_dn) else $error("rotate down wrong");
    property p_arith_dn;
        tk && req_i.op == arith_shift_down |=> wb_o.we
            && wb_o.data == {$past(req_i.operand[7]), $past(req_i.operand[7:1])}
            && flags_o[FLAG_Z] == (wb_o.data == 8'h00);
    endproperty
    a_arith_dn: assert property (p_arith_dn) else $error("arith shift wrong");
    property p_tflag;
        tk && req_i.op == bit_to_transfer_flag |=> flags_o == {$past(flags_o[7]),
            $past(req_i.operand[req_i.bit_sel]), $past(flags_o[5:0])};
    endproperty
    a_tflag: assert property (p_tflag) else $error("transfer flag wrong");
    property p_wdog;
        tk && req_i.op == watchdog_restart_op |=> wdog_req_o && $stable(flags_o) ##1 !wdog_req_o;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog pulse wrong");
    // Main scenarios reached
    c_io: cover property (tk && req_i.op == io_bit_set_op ##2 done_o);
    c_rot: cover property (tk && req_i.op == rotate_up_through_carry && flags_o[FLAG_C]);
    c_wdog: cover property (wdog_req_o);
endmodule : bfiu_exec_asserts

bind bfiu_exec bfiu_exec_asserts bfiu_exec_asserts_inst (.clock_i, .sys_rst_i,
    .req_valid_i, .req_i, .ready_o, .done_o, .wb_o, .io_o, .io_rdata_i, .wdog_req_o,
    .flags_o);

// File: tb/bfiu_exec_tb.sv
module bfiu_exec_tb import bfiu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------
    // Stimulus and outputs
    // ------------
    logic clock_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0;
    logic reg_we_i = 1'b0, reg_re_i = 1'b0;
    bfiu_req_s req_i = '0;
    logic [7:0] io_rdata_i = 8'h00, reg_wdata_i = 8'h00, flags_o, reg_rdata_o, d;
    logic [3:0] reg_addr_i = 4'h0;
    logic ready_o, done_o, sleep_req_o, wdog_req_o, break_req_o;
    bfiu_wb_s wb_o, g_wb; // Live and captured write-back
    bfiu_io_s io_o, g_io; // Live and captured I/O access
    logic [7:0] g_fl; // Flags seen at completion
    logic [2:0] g_pl; // Sleep, watchdog, break pulses
    int g_cyc, n_mismatch = 0, check_count = 0;
    always #20 clock_i = ~clock_i;
    bfiu_exec bfiu_exec_inst (.clock_i, .sys_rst_i, .req_valid_i, .req_i, .ready_o, .done_o,
        .wb_o, .io_o, .io_rdata_i, .sleep_req_o, .wdog_req_o, .break_req_o, .flags_o,
        .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);
    // ------------
    // Shared tasks
    // ------------
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task tmo;
        n_mismatch++;
        $display("unexpected at %0t: wait ran out", $time);
        finish_test;
    endtask : tmo
    task chk(input logic [7:0] g, input logic [7:0] e, input string m);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clock_i);
        reg_we_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clock_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_re_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    // Holds the request until taken, then counts cycles to done
    task run(input bfiu_op_e o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] q);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_i <= '{o, a, b, 5'h03, 5'h1a};
        io_rdata_i <= q; // Zero-wait I/O read answer
        #1 g_cyc = 0;
        while (ready_o !== 1'b1) begin
            @(posedge clock_i);
            #1 g_cyc++;
            if (g_cyc > 8) tmo;
        end
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1 g_cyc = 1;
        while (done_o !== 1'b1) begin
            @(posedge clock_i);
            #1 g_cyc++;
            if (g_cyc > 8) tmo;
        end
        {g_fl, g_wb, g_io, g_pl} = {flags_o, wb_o, io_o, sleep_req_o, wdog_req_o, break_req_o};
    endtask : run
    // ------------
    // Scenarios
    // ------------
    task t_reg;
        chk(flags_o, 8'h00, "reset flags");
        rd(4'hf);
        chk(d, 8'h00, "unmapped read");
        wr(REG_FLAGS, 8'ha5);
        rd(REG_FLAGS);
        chk(d, 8'ha5, "flags readback");
        $display("test reg done");
    endtask : t_reg
    task t_io;
        wr(REG_FLAGS, 8'h5a);
        run(io_bit_set_op, 8'h00, 3'h7, 8'h11);
        chk(g_io.wdata, 8'h91, "io set");
        chk({g_fl[6:0], g_io.we}, 8'hb5, "io set flags");
        chk(8'(g_cyc), 8'h02, "io set cycles");
        chk({g_io.re, 2'h0, g_io.addr}, 8'h1a, "io address");
        rd(REG_IO_BYTE);
        chk(d, 8'h91, "io byte readback");
        run(io_bit_clear_op, 8'h00, 3'h0, 8'hff);
        chk(g_io.wdata, 8'hfe, "io clear");
        chk({g_fl[6:0], g_io.we}, 8'hb5, "io clear flags");
        chk(8'(g_cyc), 8'h02, "io clear cycles");
        $display("test io done");
    endtask : t_io
    task t_shift;
        bfiu_op_e sh[5] = '{logical_shift_up, logical_shift_down, rotate_up_through_carry,
            rotate_down_through_carry, arith_shift_down};
        logic [7:0] av[3] = '{8'h80, 8'h01, 8'hc3};
        logic [7:0] f0, r, e;
        logic c, cn;
        for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 3; j++) begin
                c = (j == 1);
                f0 = {7'h28, c}; // Sign and transfer set, must survive
                wr(REG_FLAGS, f0);
                run(sh[i], av[j], 3'h0, 8'h00);
                case (sh[i])
                    logical_shift_up: {cn, r} = {av[j], 1'b0};
                    logical_shift_down: {r, cn} = {1'b0, av[j]};
                    rotate_up_through_carry: {cn, r} = {av[j], c};
                    rotate_down_through_carry: {r, cn} = {c, av[j]};
                    default: {r, cn} = {av[j][7], av[j]};
                endcase
                e = {f0[7:4], r[7] ^ cn, r[7], r == 8'h00, cn};
                chk(g_wb.data, r, "shift data");
                chk(g_fl, e, "shift flags");
                chk(8'(g_cyc), 8'h01, "shift cycles");
            end
        end
        $display("test shift done");
    endtask : t_shift
    // Each op toggles exactly one bit from an all-opposite start; the
    // generic clear and set ops are pointed at H and S by their bit select
    task t_flag;
        bfiu_op_e fo[7] = '{half_carry_set_op, half_carry_clear_op, sign_flag_set_op,
            sign_flag_clear_op, overflow_set_op, flag_clear_op, flag_set_op};
        logic [7:0] fm[7] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h20, 8'h10};
        logic [7:0] p;
        for (int i = 0; i < 7; i++) begin
            p = (i % 2 == 0) ? 8'h00 : 8'hff;
            wr(REG_FLAGS, p);
            run(fo[i], 8'h00, (i == 5) ? FLAG_H : FLAG_S, 8'h00);
            chk(g_fl, p ^ fm[i], "flag op");
            chk(8'(g_cyc), 8'h01, "flag cycles");
        end
        $display("test flag done");
    endtask : t_flag
    task t_tbit;
        wr(REG_FLAGS, 8'hff);
        run(bit_to_transfer_flag, 8'hdf, 3'h5, 8'h00);
        chk(g_fl, 8'hbf, "bit to T");
        wr(REG_FLAGS, 8'h40);
        run(transfer_flag_to_bit, 8'h00, 3'h7, 8'h00);
        chk(g_wb.data, 8'h80, "T to bit");
        chk(g_fl, 8'h40, "T to bit flags");
        chk({3'h0, g_wb.idx}, 8'h03, "write-back index");
        run(nibble_swap_op, 8'h3c, 3'h0, 8'h00);
        chk(g_wb.data, 8'hc3, "swap");
        chk({g_fl[7:1], g_wb.we}, 8'h41, "swap flags");
        rd(REG_RESULT);
        chk(d, 8'hc3, "result readback");
        $display("test tbit done");
    endtask : t_tbit
    // The contract gives break no cycle count, so only its pulse and flags are judged
    task t_sys;
        bfiu_op_e so[3] = '{sleep_op, watchdog_restart_op, break_op};
        wr(REG_FLAGS, 8'ha5);
        for (int i = 0; i < 3; i++) begin
            run(so[i], 8'h00, 3'h0, 8'h00);
            chk({g_pl, g_fl[4:0]}, {3'b100 >> i, 5'h05}, "control pulse");
            if (i < 2) chk(8'(g_cyc), 8'h01, "control cycles");
        end
        $display("test sys done");
    endtask : t_sys
    // ------------
    // Main sequence
    // ------------
    initial begin
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        #1 t_reg;
        t_io;
        t_shift;
        t_flag;
        t_tbit;
        t_sys;
        finish_test;
    end
endmodule : bfiu_exec_tb
